// File: verilog/ssg_regs.svh
// register map, field positions, reset values and scale constants of the speed gain/standstill block
// assumes: included by its bare name; APB byte addresses, one 32-bit word per register
`ifndef SSG_REGS_SVH
`define SSG_REGS_SVH
`define SSG_OFS_CTRL 8'h00
`define SSG_OFS_BRK 8'h04
`define SSG_OFS_NGAIN 8'h08
`define SSG_OFS_NTIME 8'h0c
`define SSG_OFS_LGAIN 8'h10
`define SSG_OFS_LTIME 8'h14
`define SSG_OFS_RSCALE 8'h18
`define SSG_OFS_QSPD 8'h1c
`define SSG_OFS_QCUR 8'h20
`define SSG_OFS_ZTHR 8'h24
`define SSG_OFS_STAT 8'h28
`define SSG_OFS_ISTAT 8'h2c
`define SSG_OFS_IMASK 8'h30
`define SSG_OFS_APPLY 8'h34
`define SSG_CTRL_MODE_LO 0
`define SSG_CTRL_MODE_HI 1
`define SSG_CTRL_SSEN 2
`define SSG_CTRL_ZQEN 3
`define SSG_LO_HI 15
`define SSG_HI_LO 16
`define SSG_HI_HI 31
`define SSG_IRQ_HI 3
`define SSG_RST_BRK_LO 16'h03e8
`define SSG_RST_BRK_HI 16'h0bb8
`define SSG_RST_GAIN 16'h03e8
`define SSG_RST_TIME 16'h01f4
`define SSG_SCALE_ONE 16'h2710
`define SSG_RST_QTHR 16'h0064
`define SSG_RST_ZTHR 16'h0032
`endif

// File: verilog/ssg_pkg.sv
// types shared by the speed gain schedule / standstill block
// assumes: constants live in ssg_regs.svh
`default_nettype none
package ssg_pkg;
  typedef enum logic [1:0] {
    SSG_MODE_OFF = 2'b00,
    SSG_MODE_FBK = 2'b01,
    SSG_MODE_ERR = 2'b10,
    SSG_MODE_CUR = 2'b11
  } ssg_mode_e;
  typedef enum logic {
    SSG_SS_RUN = 1'b0,
    SSG_SS_INHIBIT = 1'b1
  } ssg_ss_e;
  typedef struct packed {
    ssg_mode_e mode;
    logic ss_en;
    logic zq_en;
    logic [15:0] brk_lo;
    logic [15:0] brk_hi;
    logic [15:0] n_gain;
    logic [15:0] n_time;
    logic [15:0] l_gain;
    logic [15:0] l_time;
    logic [15:0] r_scale;
    logic [15:0] q_spd;
    logic [15:0] q_cur;
    logic [15:0] z_thr;
  } ssg_cfg_s;
  typedef struct packed {
    logic zero_spd;
    logic zero_sp;
    logic standstill;
    logic cut;
  } ssg_flags_s;
  typedef struct packed {
    ssg_cfg_s cfg;
    ssg_flags_s fl;
    ssg_ss_e ss;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [15:0] prop_gain;
    logic [15:0] int_time;
    logic [15:0] int_scale;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic not_still;
    logic spd_quench;
    logic cur_quench;
    logic fire_en;
    logic cont_hold;
    logic run_led;
  } ssg_state_s;
endpackage
`default_nettype wire

// File: verilog/ssg_top.sv
// speed PI gain scheduling, ramp integral scaling, zero-speed current cut and standstill inhibit
// assumes: feedback inputs and loop_tick_i come from logic on clk_sys_i; APB slave at 25 MHz
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ssg_regs.svh"
module ssg_top #(
  parameter int AW = 8
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic loop_tick_i,
  input wire logic ramping_i,
  input wire logic signed [15:0] speed_fbk_i,
  input wire logic signed [15:0] speed_err_i,
  input wire logic signed [15:0] current_dmd_i,
  input wire logic signed [15:0] current_fbk_i,
  input wire logic signed [15:0] speed_setpoint_i,
  output logic [15:0] prop_gain_o,
  output logic [15:0] int_time_o,
  output logic [15:0] int_scale_o,
  output logic at_zero_speed_o,
  output logic at_zero_setpoint_o,
  output logic at_standstill_o,
  output logic not_standstill_o,
  output logic zero_speed_current_cut_o,
  output logic speed_loop_quench_o,
  output logic current_loop_quench_o,
  output logic firing_en_o,
  output logic contactor_hold_o,
  output logic run_led_o,
  output logic irq_o
);
  ssg_pkg::ssg_state_s s_r;
  ssg_pkg::ssg_state_s s_nxt;
  logic [15:0] mag_spd;
  logic [15:0] mag_sp;
  logic [15:0] mag_cur;
  logic [15:0] sel_x;

  // most negative code saturates to 16'h7fff so the magnitude never wraps to 16'h8000 with the sign bit set
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    logic [15:0] m;
    m = v[15] ? 16'(-v) : v;
    if (m[15])
    begin
      m = 16'h7fff;
    end
    return m;
  endfunction

  function automatic logic [15:0] lerp(input logic [15:0] lo, input logic [15:0] hi,
                                       input logic [15:0] x, input logic [15:0] b1, input logic [15:0] b2);
    logic signed [17:0] d;
    logic signed [17:0] dx;
    logic signed [35:0] p;
    logic signed [35:0] q;
    logic signed [35:0] r;
    d = $signed({2'b00, hi}) - $signed({2'b00, lo});
    dx = $signed({2'b00, x}) - $signed({2'b00, b1});
    p = d * dx;
    q = p / $signed({20'h00000, 16'(b2 - b1)});
    r = q + $signed({20'h00000, lo});
    return r[15:0];
  endfunction

  assign mag_spd = mag(speed_fbk_i);
  assign mag_sp = mag(speed_setpoint_i);
  assign mag_cur = mag(current_fbk_i);

  always_comb
  begin
    case (s_r.cfg.mode)
      ssg_pkg::SSG_MODE_FBK: sel_x = mag_spd;
      ssg_pkg::SSG_MODE_ERR: sel_x = mag(speed_err_i);
      ssg_pkg::SSG_MODE_CUR: sel_x = mag(current_dmd_i);
      default: sel_x = 16'h0000;
    endcase
  end

  always_comb
  begin
    logic rd_go;
    logic wr_go;
    logic hit;
    logic [31:0] rd;
    logic [3:0] clr;
    logic [3:0] ev;
    logic ast;
    ssg_pkg::ssg_cfg_s c;
    s_nxt = s_r;
    c = s_r.cfg;
    rd_go = psel_i && penable_i && !s_r.pready;
    // one wait state: writes commit on the edge that samples pready high
    wr_go = psel_i && penable_i && s_r.pready && pwrite_i;
    hit = 1'b1;
    rd = 32'h00000000;
    clr = 4'h0;
    ev = 4'h0;
    ast = 1'b0;
    if (paddr_i == `SSG_OFS_CTRL)
    begin
      rd[`SSG_CTRL_MODE_HI:`SSG_CTRL_MODE_LO] = c.mode;
      rd[`SSG_CTRL_SSEN] = c.ss_en;
      rd[`SSG_CTRL_ZQEN] = c.zq_en;
      if (wr_go)
      begin
        s_nxt.cfg.mode = ssg_pkg::ssg_mode_e'(pwdata_i[`SSG_CTRL_MODE_HI:`SSG_CTRL_MODE_LO]);
        s_nxt.cfg.ss_en = pwdata_i[`SSG_CTRL_SSEN];
        s_nxt.cfg.zq_en = pwdata_i[`SSG_CTRL_ZQEN];
      end
    end
    else if (paddr_i == `SSG_OFS_BRK)
    begin
      rd = {c.brk_hi, c.brk_lo};
      if (wr_go)
      begin
        s_nxt.cfg.brk_lo = pwdata_i[`SSG_LO_HI:0];
        s_nxt.cfg.brk_hi = pwdata_i[`SSG_HI_HI:`SSG_HI_LO];
      end
    end
    else if (paddr_i == `SSG_OFS_NGAIN)
    begin
      rd[`SSG_LO_HI:0] = c.n_gain;
      if (wr_go) s_nxt.cfg.n_gain = pwdata_i[`SSG_LO_HI:0];
    end
    else if (paddr_i == `SSG_OFS_NTIME)
    begin
      rd[`SSG_LO_HI:0] = c.n_time;
      if (wr_go) s_nxt.cfg.n_time = pwdata_i[`SSG_LO_HI:0];
    end
    else if (paddr_i == `SSG_OFS_LGAIN)
    begin
      rd[`SSG_LO_HI:0] = c.l_gain;
      if (wr_go) s_nxt.cfg.l_gain = pwdata_i[`SSG_LO_HI:0];
    end
    else if (paddr_i == `SSG_OFS_LTIME)
    begin
      rd[`SSG_LO_HI:0] = c.l_time;
      if (wr_go) s_nxt.cfg.l_time = pwdata_i[`SSG_LO_HI:0];
    end
    else if (paddr_i == `SSG_OFS_RSCALE)
    begin
      rd[`SSG_LO_HI:0] = c.r_scale;
      if (wr_go) s_nxt.cfg.r_scale = pwdata_i[`SSG_LO_HI:0];
    end
    else if (paddr_i == `SSG_OFS_QSPD)
    begin
      rd[`SSG_LO_HI:0] = c.q_spd;
      if (wr_go) s_nxt.cfg.q_spd = pwdata_i[`SSG_LO_HI:0];
    end
    else if (paddr_i == `SSG_OFS_QCUR)
    begin
      rd[`SSG_LO_HI:0] = c.q_cur;
      if (wr_go) s_nxt.cfg.q_cur = pwdata_i[`SSG_LO_HI:0];
    end
    else if (paddr_i == `SSG_OFS_ZTHR)
    begin
      rd[`SSG_LO_HI:0] = c.z_thr;
      if (wr_go) s_nxt.cfg.z_thr = pwdata_i[`SSG_LO_HI:0];
    end
    else if (paddr_i == `SSG_OFS_STAT)
    begin
      rd[`SSG_IRQ_HI:0] = s_r.fl;
    end
    else if (paddr_i == `SSG_OFS_ISTAT)
    begin
      rd[`SSG_IRQ_HI:0] = s_r.irq_stat;
      if (wr_go) clr = pwdata_i[`SSG_IRQ_HI:0];
    end
    else if (paddr_i == `SSG_OFS_IMASK)
    begin
      rd[`SSG_IRQ_HI:0] = s_r.irq_mask;
      if (wr_go) s_nxt.irq_mask = pwdata_i[`SSG_IRQ_HI:0];
    end
    else if (paddr_i == `SSG_OFS_APPLY)
    begin
      rd = {s_r.int_time, s_r.prop_gain};
    end
    else
    begin
      hit = 1'b0;
    end
    s_nxt.pready = rd_go;
    s_nxt.pslverr = rd_go && !hit;
    if (rd_go)
    begin
      s_nxt.prdata = hit ? rd : 32'h00000000;
    end

    // everything below except the interrupt status and the irq line (which follows IMASK writes) moves only on the speed loop tick, so the current loop sees one
    // consistent set per update even if software rewrites a setting mid-period
    if (loop_tick_i)
    begin
      if (c.mode == ssg_pkg::SSG_MODE_OFF || sel_x > c.brk_hi)
      begin
        s_nxt.prop_gain = c.n_gain;
        s_nxt.int_time = c.n_time;
      end
      else if (sel_x < c.brk_lo || c.brk_hi == c.brk_lo)
      begin
        s_nxt.prop_gain = c.l_gain;
        s_nxt.int_time = c.l_time;
      end
      else
      begin
        s_nxt.prop_gain = lerp(c.l_gain, c.n_gain, sel_x, c.brk_lo, c.brk_hi);
        s_nxt.int_time = lerp(c.l_time, c.n_time, sel_x, c.brk_lo, c.brk_hi);
      end
      s_nxt.int_scale = ramping_i ? c.r_scale : `SSG_SCALE_ONE;
      s_nxt.fl.zero_spd = mag_spd < c.z_thr;
      s_nxt.fl.zero_sp = mag_sp < c.z_thr;
      ast = s_nxt.fl.zero_spd && s_nxt.fl.zero_sp;
      s_nxt.fl.standstill = ast;
      s_nxt.fl.cut = c.zq_en && (mag_spd < c.q_spd) && (mag_cur < c.q_cur);
      case (s_r.ss)
        ssg_pkg::SSG_SS_RUN:
        begin
          if (c.ss_en && ast) s_nxt.ss = ssg_pkg::SSG_SS_INHIBIT;
        end
        ssg_pkg::SSG_SS_INHIBIT:
        begin
          if (!ast || !c.ss_en) s_nxt.ss = ssg_pkg::SSG_SS_RUN;
        end
        default: s_nxt.ss = ssg_pkg::SSG_SS_RUN;
      endcase
      ev[0] = (s_nxt.ss == ssg_pkg::SSG_SS_INHIBIT) && (s_r.ss == ssg_pkg::SSG_SS_RUN);
      ev[1] = (s_nxt.ss == ssg_pkg::SSG_SS_RUN) && (s_r.ss == ssg_pkg::SSG_SS_INHIBIT);
      ev[2] = s_nxt.fl.cut && !s_r.fl.cut;
      ev[3] = !s_nxt.fl.cut && s_r.fl.cut;
    end
    // a new event outranks a software clear in the same cycle
    s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    // decoded from the next state so each drive output leaves a flop in step with its cause
    s_nxt.not_still = !s_nxt.fl.standstill;
    s_nxt.spd_quench = s_nxt.ss == ssg_pkg::SSG_SS_INHIBIT;
    s_nxt.cur_quench = (s_nxt.ss == ssg_pkg::SSG_SS_INHIBIT) || s_nxt.fl.cut;
    s_nxt.fire_en = s_nxt.ss != ssg_pkg::SSG_SS_INHIBIT;
    s_nxt.cont_hold = (s_nxt.ss == ssg_pkg::SSG_SS_INHIBIT) || s_nxt.fl.cut;
    s_nxt.run_led = s_nxt.ss == ssg_pkg::SSG_SS_INHIBIT;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      s_r <= '0;
      s_r.cfg.brk_lo <= `SSG_RST_BRK_LO;
      s_r.cfg.brk_hi <= `SSG_RST_BRK_HI;
      s_r.cfg.n_gain <= `SSG_RST_GAIN;
      s_r.cfg.n_time <= `SSG_RST_TIME;
      s_r.cfg.l_gain <= `SSG_RST_GAIN;
      s_r.cfg.l_time <= `SSG_RST_TIME;
      s_r.cfg.r_scale <= `SSG_SCALE_ONE;
      s_r.cfg.q_spd <= `SSG_RST_QTHR;
      s_r.cfg.q_cur <= `SSG_RST_QTHR;
      s_r.cfg.z_thr <= `SSG_RST_ZTHR;
      s_r.prop_gain <= `SSG_RST_GAIN;
      s_r.int_time <= `SSG_RST_TIME;
      s_r.int_scale <= `SSG_SCALE_ONE;
      s_r.not_still <= 1'b1;
      s_r.fire_en <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign prop_gain_o = s_r.prop_gain;
  assign int_time_o = s_r.int_time;
  assign int_scale_o = s_r.int_scale;
  assign at_zero_speed_o = s_r.fl.zero_spd;
  assign at_zero_setpoint_o = s_r.fl.zero_sp;
  assign at_standstill_o = s_r.fl.standstill;
  assign not_standstill_o = s_r.not_still;
  // cut drops only the current; the speed loop keeps running for a fast restart
  assign zero_speed_current_cut_o = s_r.fl.cut;
  assign speed_loop_quench_o = s_r.spd_quench;
  assign current_loop_quench_o = s_r.cur_quench;
  assign firing_en_o = s_r.fire_en;
  assign contactor_hold_o = s_r.cont_hold;
  assign run_led_o = s_r.run_led;
  assign irq_o = s_r.irq;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  property p_mode_off;
    loop_tick_i && s_r.cfg.mode == ssg_pkg::SSG_MODE_OFF |=> prop_gain_o == $past(s_r.cfg.n_gain);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode 0 did not apply normal gain");

  property p_above_high;
    loop_tick_i && s_r.cfg.mode != ssg_pkg::SSG_MODE_OFF && sel_x > s_r.cfg.brk_hi
      |=> prop_gain_o == $past(s_r.cfg.n_gain) && int_time_o == $past(s_r.cfg.n_time);
  endproperty
  a_above_high: assert property (p_above_high) else $error("normal gains not used above high breakpoint");

  property p_between;
    loop_tick_i && s_r.cfg.mode != ssg_pkg::SSG_MODE_OFF && sel_x > s_r.cfg.brk_lo && sel_x < s_r.cfg.brk_hi
      |=> (prop_gain_o >= $past(s_r.cfg.l_gain) && prop_gain_o <= $past(s_r.cfg.n_gain))
        || (prop_gain_o <= $past(s_r.cfg.l_gain) && prop_gain_o >= $past(s_r.cfg.n_gain));
  endproperty
  a_between: assert property (p_between) else $error("interpolated gain out of range");

  property p_below_gain;
    loop_tick_i && s_r.cfg.mode != ssg_pkg::SSG_MODE_OFF && sel_x < s_r.cfg.brk_lo && sel_x <= s_r.cfg.brk_hi
      |=> prop_gain_o == $past(s_r.cfg.l_gain);
  endproperty
  a_below_gain: assert property (p_below_gain) else $error("low gain not used below low breakpoint");

  property p_below_time;
    loop_tick_i && s_r.cfg.mode != ssg_pkg::SSG_MODE_OFF && sel_x < s_r.cfg.brk_lo && sel_x <= s_r.cfg.brk_hi
      |=> int_time_o == $past(s_r.cfg.l_time);
  endproperty
  a_below_time: assert property (p_below_time) else $error("low time not used below low breakpoint");

  property p_ramp;
    loop_tick_i |=> int_scale_o == ($past(ramping_i) ? $past(s_r.cfg.r_scale) : `SSG_SCALE_ONE);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp integral scale wrong");

  property p_cut;
    loop_tick_i |=> zero_speed_current_cut_o == $past(s_r.cfg.zq_en && mag_spd < s_r.cfg.q_spd
      && mag_cur < s_r.cfg.q_cur);
  endproperty
  a_cut: assert property (p_cut) else $error("zero speed cut condition wrong");

  property p_zero_flags;
    loop_tick_i |=> at_zero_speed_o == $past(mag_spd < s_r.cfg.z_thr)
      && at_zero_setpoint_o == $past(mag_sp < s_r.cfg.z_thr);
  endproperty
  a_zero_flags: assert property (p_zero_flags) else $error("zero flags wrong");

  property p_standstill;
    at_standstill_o == (at_zero_speed_o && at_zero_setpoint_o) && not_standstill_o != at_standstill_o;
  endproperty
  a_standstill: assert property (p_standstill) else $error("standstill flag inconsistent");

  property p_inhibit;
    speed_loop_quench_o |-> !firing_en_o && contactor_hold_o && run_led_o && current_loop_quench_o;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit outputs inconsistent");

  property p_hold;
    speed_loop_quench_o && !loop_tick_i |=> speed_loop_quench_o;
  endproperty
  a_hold: assert property (p_hold) else $error("inhibit left without a tick");

  property p_tick_only;
    !loop_tick_i |=> $stable(prop_gain_o) && $stable(at_standstill_o);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("outputs moved without a tick");

  c_inhibit: cover property (loop_tick_i ##1 speed_loop_quench_o ##[1:50] !speed_loop_quench_o);
  c_cut: cover property (zero_speed_current_cut_o && !speed_loop_quench_o);
  c_lerp: cover property (loop_tick_i && sel_x > s_r.cfg.brk_lo && sel_x < s_r.cfg.brk_hi);
  c_irq: cover property (irq_o);
endmodule
`default_nettype wire

// File: test/ssg_cur_model.sv
// stand-in for the current loop and thyristor firing stage fed by the gain/standstill block
// assumes: shares clk_sys_i and srst_i with the design; currents in 0.01 % per lsb
`timescale 1ns/1ps
`default_nettype none
module ssg_cur_model (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic signed [15:0] current_dmd_i,
  input wire logic current_loop_quench_i,
  input wire logic firing_en_i,
  output logic signed [15:0] current_fbk_o
);
  logic signed [15:0] tgt;
  int diff;
  // with firing stopped or the loop quenched the bridge conducts nothing
  always_comb tgt = (current_loop_quench_i || !firing_en_i) ? 16'sh0000 : current_dmd_i;
  always_comb diff = int'(tgt) - int'(current_fbk_o);
  // current slews, it never jumps, so the design sees real intermediate values
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      current_fbk_o <= 16'sh0000;
    else if (diff > 500)
      current_fbk_o <= current_fbk_o + 16'sh01f4;
    else if (diff < -500)
      current_fbk_o <= current_fbk_o - 16'sh01f4;
    else
      current_fbk_o <= tgt;
  end
endmodule
`default_nettype wire

// File: test/test_speed_gain_schedule_standstill.sv
// self-checking bench for ssg_top: gain schedule, ramp scaling, current cut, standstill inhibit
// assumes: ssg_cur_model closes the current loop; registers reached over APB
`timescale 1ns/1ps
`default_nettype none
`include "ssg_regs.svh"
module test_speed_gain_schedule_standstill;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, er, loop_tick_i = 1'b0, ramping_i = 1'b0;
  logic signed [15:0] speed_fbk_i = 16'sh0, speed_err_i = 16'sh0, current_dmd_i = 16'sh0;
  logic signed [15:0] speed_setpoint_i = 16'sh0, current_fbk_i;
  logic [15:0] prop_gain_o, int_time_o, int_scale_o;
  logic at_zero_speed_o, at_zero_setpoint_o, at_standstill_o, not_standstill_o, zero_speed_current_cut_o;
  logic speed_loop_quench_o, current_loop_quench_o, firing_en_o, contactor_hold_o, run_led_o, irq_o;
  int fails = 0, checks = 0;

  ssg_top #(.AW(8)) dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .loop_tick_i(loop_tick_i), .ramping_i(ramping_i), .speed_fbk_i(speed_fbk_i),
    .speed_err_i(speed_err_i), .current_dmd_i(current_dmd_i), .current_fbk_i(current_fbk_i),
    .speed_setpoint_i(speed_setpoint_i), .prop_gain_o(prop_gain_o), .int_time_o(int_time_o),
    .int_scale_o(int_scale_o), .at_zero_speed_o(at_zero_speed_o), .at_zero_setpoint_o(at_zero_setpoint_o),
    .at_standstill_o(at_standstill_o), .not_standstill_o(not_standstill_o),
    .zero_speed_current_cut_o(zero_speed_current_cut_o), .speed_loop_quench_o(speed_loop_quench_o),
    .current_loop_quench_o(current_loop_quench_o), .firing_en_o(firing_en_o),
    .contactor_hold_o(contactor_hold_o), .run_led_o(run_led_o), .irq_o(irq_o));

  ssg_cur_model part_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .current_dmd_i(current_dmd_i),
    .current_loop_quench_i(current_loop_quench_o), .firing_en_i(firing_en_o), .current_fbk_o(current_fbk_i));

  initial
  begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task test_done;
    begin
      if (fails == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      checks++;
      if (g !== e)
      begin
        fails++;
        $display("BAD %s expected %h seen %h", n, e, g);
      end
    end
  endtask

  // one APB transfer; the wait for pready is bounded so a dead slave cannot hang the run
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do
      begin
        @(posedge clk_sys_i);
        n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 20)
        chk("pready", 1, 0);
    end
  endtask

  task tick(input logic [15:0] spd, err, dmd, sp, input logic rmp);
    begin
      @(posedge clk_sys_i);
      speed_fbk_i <= spd;
      speed_err_i <= err;
      current_dmd_i <= dmd;
      speed_setpoint_i <= sp;
      ramping_i <= rmp;
      loop_tick_i <= 1'b1;
      @(posedge clk_sys_i);
      loop_tick_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
    end
  endtask

  task t_reset;
    begin
      chk("prop_gain", 32'h03e8, prop_gain_o);
      chk("int_time", 32'h01f4, int_time_o);
      chk("int_scale", 32'h2710, int_scale_o);
      chk("flags", 32'h18, {firing_en_o, not_standstill_o, at_standstill_o, contactor_hold_o, irq_o});
      apb(1'b0, `SSG_OFS_BRK, 32'h0);
      chk("brk", 32'h0bb8_03e8, rd);
      apb(1'b0, 8'hfc, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], er});
    end
  endtask

  task t_gain;
    logic [15:0] xs [3];
    logic [15:0] eg [3];
    logic [15:0] et [3];
    logic [15:0] q [4];
    begin
      xs = '{16'h01f4, 16'h07d0, 16'h1388};
      eg = '{16'h07d0, 16'h05dc, 16'h03e8};
      et = '{16'h0064, 16'h012c, 16'h01f4};
      apb(1'b1, `SSG_OFS_LGAIN, 32'h07d0);
      apb(1'b1, `SSG_OFS_LTIME, 32'h0064);
      for (int m = 0; m < 4; m++)
      begin
        apb(1'b1, `SSG_OFS_CTRL, 32'(m));
        for (int i = 0; i < 3; i++)
        begin
          for (int k = 1; k < 4; k++)
            q[k] = (m == 0 || m == k) ? xs[i] : 16'h1388;
          tick(q[1], q[2], q[3], 16'h1388, 1'b0);
          chk("prop_gain", (m == 0) ? 32'h03e8 : 32'(eg[i]), prop_gain_o);
          chk("int_time", (m == 0) ? 32'h01f4 : 32'(et[i]), int_time_o);
        end
      end
    end
  endtask

  task t_ramp;
    begin
      apb(1'b1, `SSG_OFS_RSCALE, 32'h1388);
      tick(16'h1388, 16'h0, 16'h0, 16'h1388, 1'b1);
      chk("int_scale", 32'h1388, int_scale_o);
      tick(16'h1388, 16'h0, 16'h0, 16'h1388, 1'b0);
      chk("int_scale", 32'h2710, int_scale_o);
    end
  endtask

  task t_still;
    begin
      apb(1'b1, `SSG_OFS_CTRL, 32'h4);
      apb(1'b1, `SSG_OFS_IMASK, 32'h1);
      tick(16'h000a, 16'h0, 16'h0, 16'h0032, 1'b0);
      chk("zero_sp_edge", 32'h2, {at_zero_setpoint_o, at_zero_speed_o, at_standstill_o});
      tick(16'h000a, 16'h0, 16'h0, 16'h000a, 1'b0);
      chk("still", 32'h7f, {at_zero_speed_o, at_zero_setpoint_o, at_standstill_o, speed_loop_quench_o,
        current_loop_quench_o, contactor_hold_o, run_led_o});
      chk("fire_ns", 32'h0, {firing_en_o, not_standstill_o});
      chk("irq", 32'h1, irq_o);
      apb(1'b0, `SSG_OFS_STAT, 32'h0);
      chk("stat", 32'he, rd);
      tick(16'h000a, 16'h0, 16'h0, 16'h000a, 1'b0);
      chk("held", 32'h1, speed_loop_quench_o);
      tick(16'h003c, 16'h0, 16'h0, 16'h000a, 1'b0);
      chk("left", 32'h18, {firing_en_o, not_standstill_o, at_standstill_o, speed_loop_quench_o, run_led_o});
      apb(1'b1, `SSG_OFS_ISTAT, 32'h1);
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk("irq_clr", 32'h0, irq_o);
      apb(1'b0, `SSG_OFS_ISTAT, 32'h0);
      chk("istat", 32'h2, rd);
    end
  endtask

  task t_cut;
    begin
      apb(1'b1, `SSG_OFS_CTRL, 32'h8);
      repeat (2) tick(16'h000a, 16'h0, 16'h0032, 16'h1388, 1'b0);
      chk("cut", 32'hd, {zero_speed_current_cut_o, contactor_hold_o, speed_loop_quench_o, firing_en_o});
      chk("cur_q", 32'h1, current_loop_quench_o);
      tick(16'h012c, 16'h0, 16'h0032, 16'h1388, 1'b0);
      chk("cut_spd", 32'h0, zero_speed_current_cut_o);
      // build the current up while speed keeps the cut off; once cut, the bridge would carry nothing
      tick(16'h012c, 16'h0, 16'h07d0, 16'h1388, 1'b0);
      tick(16'h000a, 16'h0, 16'h07d0, 16'h1388, 1'b0);
      chk("cut_cur", 32'h0, zero_speed_current_cut_o);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1;
    t_reset;
    t_gain;
    t_ramp;
    t_still;
    t_cut;
    test_done;
  end

  // the whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
